// File: ppm_port_pin_mux.sv
module ppm_port_pin_mux
(
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ppm_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // pins, flat vector, port 3 at bit 0
    input  wire logic [ppm_pkg::PIN_COUNT-1:0] pinIn,
    output logic      [ppm_pkg::PIN_COUNT-1:0] pinOut,
    output logic      [ppm_pkg::PIN_COUNT-1:0] pinOe,
    output logic      [ppm_pkg::PIN_COUNT-1:0] pullEn,
    // on-chip peripherals, same bit order as the pins
    input  wire logic [ppm_pkg::PIN_COUNT-1:0] periphOut,
    input  wire logic [ppm_pkg::PIN_COUNT-1:0] periphOe,
    output logic      [ppm_pkg::PIN_COUNT-1:0] periphIn,
    // interrupt requests
    output logic      [ppm_pkg::PIN_COUNT-1:0] extIrqPulse,
    output logic                               keyIrq
);

    typedef logic [ppm_pkg::NUM_PORTS-1:0][15:0] ppm_bank_type;

    typedef struct packed
    {
        logic [ppm_pkg::PIN_COUNT-1:0] sync1;
        logic [ppm_pkg::PIN_COUNT-1:0] sync2;
        ppm_bank_type                  latch;
        ppm_bank_type                  dir;
        ppm_bank_type                  mode;
        ppm_bank_type                  pull;
        ppm_bank_type                  rise;
        ppm_bank_type                  fall;
        logic [7:0]                    keyMode;
        logic [7:0]                    keyPrev;
        logic                          keyIrq;
        logic [ppm_pkg::PIN_COUNT-1:0] pinOut;
        logic [ppm_pkg::PIN_COUNT-1:0] pinOe;
        logic [ppm_pkg::PIN_COUNT-1:0] pullEn;
        logic [ppm_pkg::PIN_COUNT-1:0] periphIn;
        logic [31:0]                   prdata;
        logic                          pready;
        logic                          pslverr;
    } ppm_state_type;

    ppm_state_type st_q;
    ppm_state_type st_d;

    // per-port views and their flat images
    ppm_bank_type                  ctrlP;
    ppm_bank_type                  readP;
    logic [ppm_pkg::PIN_COUNT-1:0] ctrlFlat;
    logic [ppm_pkg::PIN_COUNT-1:0] dirFlat;
    logic [ppm_pkg::PIN_COUNT-1:0] latchFlat;
    logic [ppm_pkg::PIN_COUNT-1:0] analogFlat;
    logic [ppm_pkg::PIN_COUNT-1:0] pullFlat;
    logic [ppm_pkg::PIN_COUNT-1:0] riseFlat;
    logic [ppm_pkg::PIN_COUNT-1:0] fallFlat;
    logic [ppm_pkg::PIN_COUNT-1:0] edgeEnFlat;
    logic [7:0]                    keyLevel;
    logic [7:0]                    keyReady;

    // bus decode
    logic                          setup;
    logic                          access;
    logic [2:0]                    portSel;
    logic [2:0]                    regSel;
    logic                          inPortArea;

    assign setup      = psel & ~penable;
    assign access     = psel & penable & st_q.pready;
    assign portSel    = paddr[ppm_pkg::PORT_SEL_LSB +: 3];
    assign regSel     = paddr[ppm_pkg::REG_SEL_LSB +: 3];
    assign inPortArea = paddr[ppm_pkg::ADDR_W-1:8] == ppm_pkg::PORT_AREA_TOP;

    // per-port gating, sliced into the flat pin vector
    generate
        for (genvar p = 0; p < ppm_pkg::NUM_PORTS; p++)
        begin : g_port
            localparam int B = ppm_pkg::PORT_BASE[p];
            localparam int W = ppm_pkg::PORT_WIDTH[p];
            logic [15:0] pinP;
            assign pinP = 16'(st_q.sync2[B +: W]);
            // only masked bits can leave port mode
            assign ctrlP[p] = st_q.mode[p] & ppm_pkg::CTRL_MASK[p];
            // input bits read the pin, output bits read the latch
            assign readP[p] = ((st_q.dir[p] & pinP) | (~st_q.dir[p] & st_q.latch[p]))
                              & ppm_pkg::WIDTH_MASK[p];
            assign ctrlFlat[B +: W]   = ctrlP[p][W-1:0];
            assign dirFlat[B +: W]    = st_q.dir[p][W-1:0];
            assign latchFlat[B +: W]  = st_q.latch[p][W-1:0];
            assign analogFlat[B +: W] = {W{ppm_pkg::ANALOG_PORT[p]}};
            // pull-up only where the port has one
            assign pullFlat[B +: W]   = st_q.pull[p][W-1:0];
            // port 6 uses its low three edge selects
            assign riseFlat[B +: W]   = st_q.rise[p][W-1:0];
            assign fallFlat[B +: W]   = st_q.fall[p][W-1:0];
            // edges only on the masked bits
            assign edgeEnFlat[B +: W] = ctrlP[p][W-1:0] & st_q.dir[p][W-1:0]
                                        & ppm_pkg::EDGE_MASK[p][W-1:0];
        end
    endgenerate

    // key lines: port 5 low six bits, port 9 bits 8 and 9
    assign keyLevel = {st_q.sync2[ppm_pkg::KEY_HIGH_BIT1], st_q.sync2[ppm_pkg::KEY_HIGH_BIT0],
                       st_q.sync2[ppm_pkg::KEY_LOW_BASE +: ppm_pkg::KEY_LOW_COUNT]};
    // enabled key line must be a control-mode input
    assign keyReady = st_q.keyMode
        & {ctrlFlat[ppm_pkg::KEY_HIGH_BIT1] & dirFlat[ppm_pkg::KEY_HIGH_BIT1],
           ctrlFlat[ppm_pkg::KEY_HIGH_BIT0] & dirFlat[ppm_pkg::KEY_HIGH_BIT0],
           ctrlFlat[ppm_pkg::KEY_LOW_BASE +: ppm_pkg::KEY_LOW_COUNT]
           & dirFlat[ppm_pkg::KEY_LOW_BASE +: ppm_pkg::KEY_LOW_COUNT]};

    // next state: synchronisers, register file, pin drivers
    always_comb
    begin
        st_d = st_q;

        // pins pass two flops before any use
        st_d.sync1 = pinIn;
        st_d.sync2 = st_q.sync1;

        // zero-wait slave: answer prepared during setup
        st_d.pready  = setup;
        st_d.pslverr = 1'b0;
        st_d.prdata  = 32'h0000_0000;
        if (setup)
        begin
            if (paddr == ppm_pkg::KEY_MODE_ADDR)
                st_d.prdata = {24'h00_0000, st_q.keyMode};
            else if (!inPortArea || paddr[1:0] != 2'h0)
                st_d.pslverr = 1'b1;
            else
            begin
                unique case (regSel)
                    ppm_pkg::REG_DATA:     st_d.prdata = {16'h0000, readP[portSel]};
                    ppm_pkg::REG_DIR:      st_d.prdata = {16'h0000,
                        portSel == 3'(ppm_pkg::PORT7_IDX)
                        ? {8'h00, st_q.dir[portSel][ppm_pkg::HALF-1:0]}
                        : st_q.dir[portSel]};
                    ppm_pkg::REG_MODE:     st_d.prdata = {16'h0000, st_q.mode[portSel]};
                    ppm_pkg::REG_PULLUP:   st_d.prdata = {16'h0000, st_q.pull[portSel]};
                    ppm_pkg::REG_RISE:     st_d.prdata = {16'h0000, st_q.rise[portSel]};
                    ppm_pkg::REG_FALL:     st_d.prdata = {16'h0000, st_q.fall[portSel]};
                    ppm_pkg::REG_DIR_HIGH:
                    begin
                        if (portSel == 3'(ppm_pkg::PORT7_IDX))
                            st_d.prdata = {24'h00_0000,
                                           st_q.dir[portSel][15:ppm_pkg::HALF]};
                        else
                            st_d.pslverr = 1'b1;
                    end
                    default:               st_d.pslverr = 1'b1;
                endcase
            end
        end

        // writes land at the access edge; refused addresses change nothing
        if (access && pwrite)
        begin
            if (paddr == ppm_pkg::KEY_MODE_ADDR)
                st_d.keyMode = pwdata[7:0];
            else if (inPortArea && paddr[1:0] == 2'h0)
            begin
                unique case (regSel)
                    ppm_pkg::REG_DATA:
                        st_d.latch[portSel] = pwdata[15:0] & ppm_pkg::WIDTH_MASK[portSel];
                    ppm_pkg::REG_DIR:
                    begin
                        // port 7 high half has its own register
                        if (portSel == 3'(ppm_pkg::PORT7_IDX))
                            st_d.dir[portSel][ppm_pkg::HALF-1:0] = pwdata[ppm_pkg::HALF-1:0];
                        else
                            st_d.dir[portSel] = pwdata[15:0]
                                | ~ppm_pkg::WIDTH_MASK[portSel];
                    end
                    ppm_pkg::REG_MODE:
                        st_d.mode[portSel] = pwdata[15:0] & ppm_pkg::CTRL_MASK[portSel];
                    ppm_pkg::REG_PULLUP:
                        st_d.pull[portSel] = pwdata[15:0] & ppm_pkg::PULL_MASK[portSel];
                    ppm_pkg::REG_RISE:
                        st_d.rise[portSel] = pwdata[15:0] & ppm_pkg::EDGE_MASK[portSel];
                    ppm_pkg::REG_FALL:
                        st_d.fall[portSel] = pwdata[15:0] & ppm_pkg::EDGE_MASK[portSel];
                    ppm_pkg::REG_DIR_HIGH:
                    begin
                        if (portSel == 3'(ppm_pkg::PORT7_IDX))
                            st_d.dir[portSel][15:ppm_pkg::HALF] = pwdata[ppm_pkg::HALF-1:0];
                    end
                    default:
                    begin
                    end
                endcase
            end
        end

        // peripheral owns control-mode bits, latch owns port mode
        // serial, interrupt and timer functions ride the peripheral bus
        // clocked serial channel 0 on port 4
        // port 5 keys, timer Q0 and debug
        // port 8 interrupt and serial channel 3
        st_d.pinOut = (ctrlFlat & periphOut) | (~ctrlFlat & latchFlat);
        // serial clock direction chosen per cycle by the peripheral
        // analog control bits never drive, like port 7
        st_d.pinOe  = (ctrlFlat & ~analogFlat & periphOe) | (~ctrlFlat & ~dirFlat);
        st_d.pullEn = pullFlat;
        // control-mode pins feed the peripherals, debug unit included
        st_d.periphIn = st_q.sync2 & ctrlFlat;

        // key interrupt on a falling edge of any ready key line
        st_d.keyPrev = keyLevel;
        st_d.keyIrq  = |(keyReady & st_q.keyPrev & ~keyLevel);
    end

    // single register stage for all state
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_q         <= '0;
            st_q.dir     <= {ppm_pkg::NUM_PORTS{ppm_pkg::DIR_RESET}};
            st_q.keyMode <= ppm_pkg::KEY_RESET;
        end
        else
            st_q <= st_d;
    end

    // external interrupt edges on enabled pins
    ppm_edge_detect u_edge
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .level   (st_q.sync2),
        .riseSel (riseFlat),
        .fallSel (fallFlat),
        .enable  (edgeEnFlat),
        .pulse   (extIrqPulse)
    );

    // outputs straight from flops
    assign prdata   = st_q.prdata;
    assign pready   = st_q.pready;
    assign pslverr  = st_q.pslverr;
    assign pinOut   = st_q.pinOut;
    assign pinOe    = st_q.pinOe;
    assign pullEn   = st_q.pullEn;
    assign periphIn = st_q.periphIn;
    assign keyIrq   = st_q.keyIrq;

    // port mode output follows the latch
    latch_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> ((pinOut ^ $past(latchFlat)) & $past(~ctrlFlat & ~dirFlat)) == '0)
        else $error("port output differs from latch");

    // control mode output follows the peripheral
    periph_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> ((pinOut ^ $past(periphOut)) & $past(ctrlFlat)) == '0)
        else $error("control output differs from peripheral");

    // port mode input never drives the pin
    input_release_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> (pinOe & $past(~ctrlFlat & dirFlat)) == '0)
        else $error("input bit drives its pin");

    // analog bits in control mode never drive
    analog_hiz_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> (pinOe & $past(ctrlFlat & analogFlat)) == '0)
        else $error("analog bit drives its pin");

    // port 6 upper bits stay in port mode
    p6_port_only_a: assert property (@(posedge clk) disable iff (sys_rst)
        ctrlFlat[ppm_pkg::PORT_BASE[ppm_pkg::PORT6_IDX]+3 +: 13] == '0)
        else $error("port 6 upper bit in control mode");

    // no pull-up on the analog ports
    analog_pull_a: assert property (@(posedge clk) disable iff (sys_rst)
        pullEn[ppm_pkg::PORT_BASE[ppm_pkg::PORT7_IDX] +: 16] == '0 &&
        pullEn[ppm_pkg::PORT_BASE[ppm_pkg::PORT12_IDX] +: 8] == '0)
        else $error("pull-up on analog port");

    // pull-up output follows its register one edge later
    pull_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> pullEn == $past(pullFlat))
        else $error("pull-up output differs from register");

    // error flag only ever rides on the ready pulse
    err_ready_a: assert property (@(posedge clk) disable iff (sys_rst)
        pslverr |-> pready)
        else $error("pslverr without pready");

    // port 9 low bits raise no edge request
    p9_edge_bits_a: assert property (@(posedge clk) disable iff (sys_rst)
        extIrqPulse[ppm_pkg::PORT_BASE[ppm_pkg::PORT9_IDX] +: 13] == '0)
        else $error("edge request on port 9 low bit");

    // key request needs a ready line and a falling edge
    key_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        keyIrq |-> |($past(keyReady) & $past(keyLevel, 2) & ~$past(keyLevel)))
        else $error("key request without ready falling line");

    // peripheral sees the pin three edges later
    periph_path_a: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 ##3 1'b1 |-> ((periphIn ^ $past(pinIn, 3)) & $past(ctrlFlat)) == '0)
        else $error("peripheral input not the synchronised pin");

    // zero-wait answer to every setup
    apb_ready_a: assert property (@(posedge clk) disable iff (sys_rst)
        psel && !penable |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");

    key_seen_c:   cover property (@(posedge clk) disable iff (sys_rst) keyIrq);
    edge_seen_c:  cover property (@(posedge clk) disable iff (sys_rst) |extIrqPulse);
    ctrl_write_c: cover property (@(posedge clk) disable iff (sys_rst)
        access && pwrite && regSel == ppm_pkg::REG_MODE);
    err_seen_c:   cover property (@(posedge clk) disable iff (sys_rst) pready && pslverr);

endmodule : ppm_port_pin_mux

// File: ppm_pkg.sv
package ppm_pkg;

    // port list order: 3, 4, 5, 6, 7, 8, 9, 12
    localparam int NUM_PORTS = 8;
    localparam int PIN_COUNT = 77;
    localparam int HALF      = 8;

    localparam int PORT3_IDX  = 0;
    localparam int PORT4_IDX  = 1;
    localparam int PORT5_IDX  = 2;
    localparam int PORT6_IDX  = 3;
    localparam int PORT7_IDX  = 4;
    localparam int PORT8_IDX  = 5;
    localparam int PORT9_IDX  = 6;
    localparam int PORT12_IDX = 7;

    // position of each port inside the flat pin vector
    localparam int PORT_BASE [NUM_PORTS]  = '{0, 10, 13, 19, 35, 51, 53, 69};
    localparam int PORT_WIDTH [NUM_PORTS] = '{10, 3, 6, 16, 16, 2, 16, 8};

    // bits that exist on each port
    localparam logic [15:0] WIDTH_MASK [NUM_PORTS] = '{
        16'h03FF, 16'h0007, 16'h003F, 16'hFFFF, 16'hFFFF, 16'h0003, 16'hFFFF, 16'h00FF};
    // bits that can be switched to control mode
    localparam logic [15:0] CTRL_MASK [NUM_PORTS] = '{
        16'h03FF, 16'h0007, 16'h003F, 16'h0007, 16'hFFFF, 16'h0003, 16'hFFFF, 16'h00FF};
    // bits with a valid interrupt edge
    localparam logic [15:0] EDGE_MASK [NUM_PORTS] = '{
        16'h03FF, 16'h0000, 16'h0000, 16'h0007, 16'h0000, 16'h0003, 16'hE000, 16'h0000};
    // bits with an on-chip pull-up
    localparam logic [15:0] PULL_MASK [NUM_PORTS] = '{
        16'h03FF, 16'h0007, 16'h003F, 16'hFFFF, 16'h0000, 16'h0003, 16'hFFFF, 16'h0000};
    // ports whose control mode is analog input (ports 7 and 12)
    localparam logic [NUM_PORTS-1:0] ANALOG_PORT = 8'h90;

    // reset values
    localparam logic [15:0] DIR_RESET  = 16'hFFFF;
    localparam logic [15:0] ZERO16     = 16'h0000;
    localparam logic [7:0]  KEY_RESET  = 8'h00;

    // APB map: paddr[7:5] selects the port, paddr[4:2] the register
    localparam int          ADDR_W        = 12;
    localparam int          PORT_SEL_LSB  = 5;
    localparam int          REG_SEL_LSB   = 2;
    localparam logic [3:0]  PORT_AREA_TOP = 4'h0;
    localparam logic [2:0]  REG_DATA      = 3'h0;  // output latch / pin read
    localparam logic [2:0]  REG_DIR       = 3'h1;  // port3_direction_reg etc, 1 = input
    localparam logic [2:0]  REG_MODE      = 3'h2;  // 1 = control mode
    localparam logic [2:0]  REG_PULLUP    = 3'h3;  // port3_pullup_reg etc
    localparam logic [2:0]  REG_RISE      = 3'h4;  // port3_rise_edge_sel etc
    localparam logic [2:0]  REG_FALL      = 3'h5;  // port3_fall_edge_sel etc
    localparam logic [2:0]  REG_DIR_HIGH  = 3'h6;  // port7_high_direction_reg only
    localparam logic [ADDR_W-1:0] KEY_MODE_ADDR = 12'h100;  // key_scan_mode_reg

    // key_scan_inputs_low on port 5 bits 0..5, key_scan_inputs_high on port 9 bits 8, 9
    localparam int KEY_LOW_BASE  = 13;
    localparam int KEY_LOW_COUNT = 6;
    localparam int KEY_HIGH_BIT0 = 61;
    localparam int KEY_HIGH_BIT1 = 62;

endpackage : ppm_pkg

// File: ppm_edge_detect.sv
module ppm_edge_detect
(
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    // synchronised pin levels and edge selects
    input  wire logic [ppm_pkg::PIN_COUNT-1:0] level,
    input  wire logic [ppm_pkg::PIN_COUNT-1:0] riseSel,
    input  wire logic [ppm_pkg::PIN_COUNT-1:0] fallSel,
    input  wire logic [ppm_pkg::PIN_COUNT-1:0] enable,
    // one-cycle request per pin
    output logic      [ppm_pkg::PIN_COUNT-1:0] pulse
);

    typedef struct packed
    {
        logic [ppm_pkg::PIN_COUNT-1:0] prev;
        logic [ppm_pkg::PIN_COUNT-1:0] pulse;
    } ppm_edge_state_type;

    ppm_edge_state_type st_q;
    ppm_edge_state_type st_d;

    // both selects set means both edges are valid
    always_comb
    begin
        st_d       = st_q;
        st_d.prev  = level;
        st_d.pulse = enable & ((riseSel & level & ~st_q.prev) |
                               (fallSel & ~level & st_q.prev));
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign pulse = st_q.pulse;

    // a pulse needs an enabled, selected edge one cycle before
    edge_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
        (pulse & ~$past(enable & ((riseSel & level & ~st_q.prev) |
                                  (fallSel & ~level & st_q.prev)))) == '0)
        else $error("edge pulse without selected edge");

endmodule : ppm_edge_detect

// File: ppm_board_model.sv
module ppm_board_model
(
    // pins seen from the board
    input  wire logic [ppm_pkg::PIN_COUNT-1:0] pinOut,
    input  wire logic [ppm_pkg::PIN_COUNT-1:0] pinOe,
    input  wire logic [ppm_pkg::PIN_COUNT-1:0] pullEn,
    input  wire logic [ppm_pkg::PIN_COUNT-1:0] board,
    output logic      [ppm_pkg::PIN_COUNT-1:0] pinIn,
    // peripheral side, held steady so the mux output can be compared
    input  wire logic [31:0]                   pattern,
    output logic      [ppm_pkg::PIN_COUNT-1:0] periphOut,
    output logic      [ppm_pkg::PIN_COUNT-1:0] periphOe
);
    // pull-up wins over an undriven board line
    assign pinIn = (pinOe & pinOut) | (~pinOe & pullEn) | (~pinOe & ~pullEn & board);
    // peripherals drive or release each pin, serial clocks included
    assign periphOut = {pattern[12:0], pattern, ~pattern};
    assign periphOe  = {periphOut[38:0], periphOut[76:39]};
endmodule : ppm_board_model

// File: ppm_port_pin_mux_tb.sv
module ppm_port_pin_mux_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = ppm_pkg::PIN_COUNT;
    logic         clk, sys_rst, psel, penable, pwrite, pready, pslverr, keyIrq;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, pat, rnd;
    logic [33:0]  e;
    logic [33:0]  expQ [$];
    logic [W-1:0] pinIn, pinOut, pinOe, pullEn, periphOut, periphOe, periphIn, extIrqPulse, board;
    int           n_errors, compares, nIrq, nKey;

    ppm_port_pin_mux uut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullEn(pullEn),
        .periphOut(periphOut), .periphOe(periphOe), .periphIn(periphIn),
        .extIrqPulse(extIrqPulse), .keyIrq(keyIrq));
    ppm_board_model board_i (.pinOut(pinOut), .pinOe(pinOe), .pullEn(pullEn), .board(board),
        .pinIn(pinIn), .pattern(pat), .periphOut(periphOut), .periphOe(periphOe));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [11:0] ad(input int p, input int r);
        return 12'(p * 32 + r * 4);
    endfunction : ad
    // one port's bits out of the flat pin vector
    function automatic logic [31:0] sl(input logic [W-1:0] v, input int p);
        sl = '0;
        for (int i = 0; i < ppm_pkg::PORT_WIDTH[p]; i++)
            sl[i] = v[ppm_pkg::PORT_BASE[p] + i];
    endfunction : sl

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one apb transfer; the expected answer is queued for the monitor
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] exp, input logic err);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        expQ.push_back({~wr, err, exp});
        @(posedge clk);
        penable <= 1'b1;
        // wait states end only on pready; a hang is left to the watchdog
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
    endtask : xfer
    task automatic conclude;
        $display("counts: %0d compares, %0d mismatches", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // monitor: answers are matched in order against the queue
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1 && expQ.size() > 0)
        begin
            e = expQ.pop_front();
            chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
            if (e[33]) chk("prdata", e[31:0], prdata);
        end
        if (extIrqPulse[0] === 1'b1) nIrq++;
        if (keyIrq === 1'b1) nKey++;
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #200000;
        n_errors++;
        conclude();
    end

    initial
    begin
        sys_rst = 1'b1; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
        rnd = 32'hEEBD; pat = rnd; board = '0; n_errors = 0; compares = 0; nIrq = 0; nKey = 0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        for (int p = 0; p < 8; p++)
        begin
            xfer(0, ad(p, 1), 0, (p == 4) ? 32'h00FF : 32'hFFFF, 0);
            xfer(0, ad(p, 2), 0, 0, 0);
            xfer(1, ad(p, 2), 32'hFFFF, 0, 0);
            xfer(0, ad(p, 2), 0, {16'h0, ppm_pkg::CTRL_MASK[p]}, 0);
            if (p != 4 && p != 7) xfer(1, ad(p, 1), 0, 0, 0);
            rnd = lfsr(rnd);
            pat <= rnd;
            xfer(1, ad(p, 0), rnd, 0, 0);
            xfer(1, ad(p, 3), 32'hFFFF, 0, 0);
            repeat (2) @(posedge clk);
            chk("pullEn", {16'h0, ppm_pkg::PULL_MASK[p] & ppm_pkg::WIDTH_MASK[p]}, sl(pullEn, p));
            if (p == 4 || p == 7) chk("analog pinOe", 0, sl(pinOe, p));
            else chk("pinOut", {16'h0, ppm_pkg::CTRL_MASK[p]} & sl(periphOut, p)
                | {16'h0, ~ppm_pkg::CTRL_MASK[p]} & rnd & sl('1, p), sl(pinOut, p));
            if (p != 4 && p != 7) chk("pinOe", {16'h0, ppm_pkg::CTRL_MASK[p]} & sl(periphOe, p)
                | {16'h0, ~ppm_pkg::CTRL_MASK[p]} & sl('1, p), sl(pinOe, p));
            // output bits read back the latch; analog port data is never read back
            if (p != 4 && p != 7)
                xfer(0, ad(p, 0), 0, {16'h0, rnd[15:0] & ppm_pkg::WIDTH_MASK[p]}, 0);
            xfer(1, ad(p, 1), 32'hFFFF, 0, 0);
            xfer(1, ad(p, 2), 0, 0, 0);
            xfer(1, ad(p, 3), 0, 0, 0);
        end
        $display("test port map done");
        xfer(1, ad(0, 7), 32'hFFFF, 0, 1);
        xfer(0, ad(0, 6), 0, 0, 1);
        xfer(1, ad(4, 6), 32'h005A, 0, 0);
        xfer(0, ad(4, 6), 0, 32'h005A, 0);
        xfer(0, ad(4, 1), 0, 32'h00FF, 0);
        xfer(1, ad(4, 6), 32'h00FF, 0, 0);
        xfer(0, 12'h104, 0, 0, 1);
        $display("test refusal done");
        // peripherals release pins 0 to 37 so the board alone sets their input levels
        pat <= '0;
        xfer(1, ad(0, 2), 1, 0, 0);
        xfer(1, ad(0, 4), 1, 0, 0);
        for (int k = 0; k < 2; k++)
        begin
            board[0] <= 1'b1;
            repeat (6) @(posedge clk);
            chk("periphIn high", 32'h1, {31'h0, periphIn[0]});
            board[0] <= 1'b0;
            repeat (6) @(posedge clk);
            chk("periphIn low", 32'h0, {31'h0, periphIn[0]});
            if (k == 0) xfer(1, ad(0, 5), 1, 0, 0);
        end
        chk("edge count", 3, nIrq);
        $display("test edges done");
        xfer(1, 12'h100, 1, 0, 0);
        xfer(0, 12'h100, 0, 32'h0000_0001, 0);
        for (int k = 0; k < 2; k++)
        begin
            xfer(1, ad(2, 2), 32'(1 - k), 0, 0);
            board[13] <= 1'b1;
            repeat (6) @(posedge clk);
            board[13] <= 1'b0;
            repeat (6) @(posedge clk);
        end
        chk("key count", 1, nKey);
        $display("test keys done");
        conclude();
    end
endmodule : ppm_port_pin_mux_tb
